// >>> rtl/osc_select_ctrl.sv
// oscillator select control: three byte registers driving clock source controls
//
// Overview of operation
// - own peripheral index, byte-wide accesses only
// - bit0 general: 0 crystal, 1 on-chip; strap reset
// - bit1 general: reset tile on select change
// - on-chip bit1: 0 fast, 1 slow
// - on-chip bit0 enables it, resets to one
// - crystal bit1 enables bias, resets to one
// - crystal bit0 enables crystal, resets to one
`timescale 1ns/10ps
module osc_select_ctrl
  import osc_pkg::*;
#(
  parameter int TILE_RESET_LEN = TILE_RESET_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       source_strap,
  input  wire logic       reg_sel,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_ack,
  output logic            source_sel,
  output logic            int_osc_enable,
  output logic            int_osc_slow,
  output logic            xtal_enable,
  output logic            xtal_bias_enable,
  output logic            tile_reset
);

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  logic        wr_gen;
  logic        wr_int;
  logic        wr_xtal;
  logic        rd_req;
  logic        sel_change;
  logic        pulse_start;
  logic        strap_taken_q;
  logic        source_sel_d;
  logic        source_sel_q;
  logic        reset_on_sel_d;
  logic        reset_on_sel_q;
  logic [15:0] rst_cnt_d;
  logic [15:0] rst_cnt_q;
  logic        tile_reset_d;
  logic        tile_reset_q;
  logic        int_osc_slow_d;
  logic        int_osc_slow_q;
  logic        int_osc_enable_d;
  logic        int_osc_enable_q;
  logic        xtal_bias_d;
  logic        xtal_bias_q;
  logic        xtal_enable_d;
  logic        xtal_enable_q;
  logic [7:0]  rdata_d;
  logic [7:0]  rdata_q;
  logic        ack_q;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  // each access carries exactly one byte lane
  assign wr_gen  = reg_sel && reg_wr && (reg_addr == OSC_ADDR_CLOCK_SOURCE_SELECT);
  assign wr_int  = reg_sel && reg_wr && (reg_addr == OSC_ADDR_INTERNAL_OSC_CTRL);
  assign wr_xtal = reg_sel && reg_wr && (reg_addr == OSC_ADDR_CRYSTAL_OSC_CTRL);
  assign rd_req  = reg_sel && !reg_wr;

  // ------------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------------
  // the strap is sampled on the first edge after release, never inside reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strap_taken_q <= 1'b0;
    end else begin
      strap_taken_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // source select
  // ------------------------------------------------------------------
  // a write on the capture edge loses to the strap, so requests start one edge later
  always_comb begin
    source_sel_d = source_sel_q;
    if (!strap_taken_q) begin
      source_sel_d = source_strap;
    end else if (wr_gen) begin
      source_sel_d = reg_wdata[OSC_BIT_SOURCE_SEL];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      source_sel_q <= OSC_RST_SOURCE_SEL;
    end else begin
      source_sel_q <= source_sel_d;
    end
  end

  always_comb begin
    reset_on_sel_d = reset_on_sel_q;
    if (wr_gen) begin
      reset_on_sel_d = reg_wdata[OSC_BIT_RESET_ON_SEL];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reset_on_sel_q <= OSC_RST_RESET_ON_SEL;
    end else begin
      reset_on_sel_q <= reset_on_sel_d;
    end
  end

  // ------------------------------------------------------------------
  // tile reset pulse
  // ------------------------------------------------------------------
  // the new enable value in the same write decides, as the change happens with it
  assign sel_change  = reg_wdata[OSC_BIT_SOURCE_SEL] != source_sel_q;
  assign pulse_start = wr_gen && strap_taken_q && reg_wdata[OSC_BIT_RESET_ON_SEL] && sel_change;

  // a qualifying write during a pulse restarts the count
  always_comb begin
    rst_cnt_d = rst_cnt_q;
    if (pulse_start) begin
      rst_cnt_d = 16'(TILE_RESET_LEN - 1);
    end else if (rst_cnt_q != 16'h0000) begin
      rst_cnt_d = rst_cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_cnt_q <= 16'h0000;
    end else begin
      rst_cnt_q <= rst_cnt_d;
    end
  end

  always_comb begin
    tile_reset_d = tile_reset_q;
    if (pulse_start) begin
      tile_reset_d = 1'b1;
    end else if (rst_cnt_q == 16'h0000) begin
      tile_reset_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tile_reset_q <= 1'b0;
    end else begin
      tile_reset_q <= tile_reset_d;
    end
  end

  // ------------------------------------------------------------------
  // oscillator controls
  // ------------------------------------------------------------------
  always_comb begin
    int_osc_slow_d = int_osc_slow_q;
    if (wr_int) begin
      int_osc_slow_d = reg_wdata[OSC_BIT_INT_SLOW];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      int_osc_slow_q <= OSC_RST_INT_SLOW;
    end else begin
      int_osc_slow_q <= int_osc_slow_d;
    end
  end

  // no guard against stopping the running source: software's duty
  always_comb begin
    int_osc_enable_d = int_osc_enable_q;
    if (wr_int) begin
      int_osc_enable_d = reg_wdata[OSC_BIT_INT_ENABLE];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      int_osc_enable_q <= OSC_RST_INT_ENABLE;
    end else begin
      int_osc_enable_q <= int_osc_enable_d;
    end
  end

  always_comb begin
    xtal_bias_d = xtal_bias_q;
    if (wr_xtal) begin
      xtal_bias_d = reg_wdata[OSC_BIT_XTAL_BIAS];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      xtal_bias_q <= OSC_RST_XTAL_BIAS;
    end else begin
      xtal_bias_q <= xtal_bias_d;
    end
  end

  always_comb begin
    xtal_enable_d = xtal_enable_q;
    if (wr_xtal) begin
      xtal_enable_d = reg_wdata[OSC_BIT_XTAL_ENABLE];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      xtal_enable_q <= OSC_RST_XTAL_ENABLE;
    end else begin
      xtal_enable_q <= xtal_enable_d;
    end
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  // bits 7:2 have no storage at all, so written values there simply vanish
  always_comb begin
    rdata_d = OSC_RESERVED_ZERO;
    if (rd_req) begin
      unique case (reg_addr)
        OSC_ADDR_CLOCK_SOURCE_SELECT: rdata_d = {6'h00, reset_on_sel_q, source_sel_q};
        OSC_ADDR_INTERNAL_OSC_CTRL:   rdata_d = {6'h00, int_osc_slow_q, int_osc_enable_q};
        OSC_ADDR_CRYSTAL_OSC_CTRL:    rdata_d = {6'h00, xtal_bias_q, xtal_enable_q};
        default:                      rdata_d = OSC_RESERVED_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // every access is answered, mapped or not, so the host never waits
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= reg_sel;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign reg_rdata        = rdata_q;
  assign reg_ack          = ack_q;
  assign source_sel       = source_sel_q;
  assign int_osc_enable   = int_osc_enable_q;
  assign int_osc_slow     = int_osc_slow_q;
  assign xtal_enable      = xtal_enable_q;
  assign xtal_bias_enable = xtal_bias_q;
  assign tile_reset       = tile_reset_q;

endmodule : osc_select_ctrl

// >>> inc/osc_pkg.sv
// constants for the oscillator select control block
package osc_pkg;
  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [7:0] OSC_ADDR_CLOCK_SOURCE_SELECT = 8'h00;
  localparam logic [7:0] OSC_ADDR_INTERNAL_OSC_CTRL   = 8'h01;
  localparam logic [7:0] OSC_ADDR_CRYSTAL_OSC_CTRL    = 8'h02;
  localparam int         OSC_PERIPH_INDEX             = 4;
  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int OSC_BIT_SOURCE_SEL   = 0;
  localparam int OSC_BIT_RESET_ON_SEL = 1;
  localparam int OSC_BIT_INT_ENABLE   = 0;
  localparam int OSC_BIT_INT_SLOW     = 1;
  localparam int OSC_BIT_XTAL_ENABLE  = 0;
  localparam int OSC_BIT_XTAL_BIAS    = 1;
  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic OSC_RST_RESET_ON_SEL = 1'b0;
  localparam logic OSC_RST_INT_SLOW     = 1'b0;
  localparam logic OSC_RST_INT_ENABLE   = 1'b1;
  localparam logic OSC_RST_XTAL_BIAS    = 1'b1;
  localparam logic OSC_RST_XTAL_ENABLE  = 1'b1;
  localparam logic OSC_RST_SOURCE_SEL   = 1'b0;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_PS        = 5000;
  localparam int TILE_RESET_TIME_PS   = 80000;
  localparam int TILE_RESET_CYCLES    = (TILE_RESET_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] OSC_RESERVED_ZERO = 8'h00;
endpackage : osc_pkg

// >>> tb/osc_host.sv
// host model issuing byte accesses to the oscillator registers
`timescale 1ns/10ps
module osc_host (
  input  wire logic       clock,
  input  wire logic       reg_ack,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_sel,
  output logic            reg_wr,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial {reg_sel, reg_wr, reg_addr, reg_wdata} = 18'h0;
  task automatic acc(input logic wr, input logic [7:0] a, d, output logic [7:0] q, output bit ok);
    @(negedge clock);
    {reg_sel, reg_wr, reg_addr, reg_wdata} = {1'b1, wr, a, d};
    @(negedge clock);
    // released lines carry the inverse so a stale byte never looks valid
    {reg_sel, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    ok = reg_ack;
    q = reg_rdata;
  endtask : acc
endmodule : osc_host

// >>> tb/osc_select_ctrl_checker.sv
// concurrent checks on the oscillator select control ports
`timescale 1ns/10ps
module osc_select_ctrl_checker #(
  parameter int TILE_RESET_LEN = 16
) (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       reg_sel,
  input wire logic       reg_wr,
  input wire logic       reg_ack,
  input wire logic       source_sel,
  input wire logic       int_osc_enable,
  input wire logic       int_osc_slow,
  input wire logic       xtal_enable,
  input wire logic       xtal_bias_enable,
  input wire logic       tile_reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  localparam int LAST = TILE_RESET_LEN - 1;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire logic wr0 = reg_sel && reg_wr && reg_addr == 8'h00;
  wire logic wr1 = reg_sel && reg_wr && reg_addr == 8'h01;
  wire logic wr2 = reg_sel && reg_wr && reg_addr == 8'h02;
  wire logic trig = wr0 && reg_wdata[1] && reg_wdata[0] != source_sel;
  // a restart during a pulse is not modelled here
  sequence pulse_s; tile_reset ##LAST tile_reset ##1 !tile_reset; endsequence
  chk_ack_once: assert property (reg_ack == $past(reg_sel)) else $error("ack not one cycle after select");
  chk_sel_write: assert property (wr0 |=> source_sel == $past(reg_wdata[0])) else $error("select not written");
  chk_int_write: assert property (wr1 |=>
    int_osc_slow == $past(reg_wdata[1]) && int_osc_enable == $past(reg_wdata[0]))
    else $error("on-chip control not written");
  chk_xtal_write: assert property (wr2 |=>
    xtal_bias_enable == $past(reg_wdata[1]) && xtal_enable == $past(reg_wdata[0]))
    else $error("crystal control not written");
  chk_rsvd_zero: assert property (reg_ack |-> reg_rdata[7:2] == 6'h00) else $error("reserved bits set");
  chk_unmapped_zero: assert property (reg_sel && reg_addr > 8'h02 |=> reg_rdata == 8'h00)
    else $error("unmapped");
  chk_tile_pulse: assert property (trig |=> pulse_s) else $error("tile reset pulse wrong");
  chk_tile_cause: assert property ($rose(tile_reset) |-> $past(trig)) else $error("tile reset without cause");
endmodule : osc_select_ctrl_checker

// >>> tb/tb_top.sv
// self-checking bench for the oscillator select control
`timescale 1ns/10ps
module tb_top;
  logic clock = 1'b0, rstn = 1'b0, source_strap = 1'b0;
  logic reg_sel, reg_wr, reg_ack, tile_reset, source_sel, int_osc_enable, int_osc_slow, xtal_enable, xtal_bias_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int miscompares = 0, checks_done = 0;
  always #2.5 clock = ~clock;
  osc_host host (.clock, .reg_ack, .reg_rdata, .reg_sel, .reg_wr, .reg_addr, .reg_wdata);
  osc_select_ctrl #(.TILE_RESET_LEN(2)) uut (.clock, .rstn, .source_strap, .reg_sel, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_ack, .source_sel, .int_osc_enable, .int_osc_slow, .xtal_enable, .xtal_bias_enable, .tile_reset);
  task automatic complete_run;
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic acc(input logic wr, input logic [7:0] a, d, exp);
    logic [7:0] q;
    bit ok;
    host.acc(wr, a, d, q, ok);
    cmp({7'h00, ok}, 8'h01);
    // without an answer the bus is dead and nothing later would mean anything
    if (!ok) complete_run();
    cmp(q, exp);
  endtask : acc
  function automatic logic [7:0] outs();
    return {3'h0, source_sel, int_osc_enable, int_osc_slow, xtal_enable, xtal_bias_enable};
  endfunction : outs
  task automatic t_reset(input logic strap);
    @(negedge clock);
    rstn = 1'b0;
    source_strap = strap;
    repeat (16) @(negedge clock);
    cmp(outs(), 8'h0b);
    rstn = 1'b1;
    repeat (2) @(negedge clock);
    cmp(outs(), {3'h0, strap, 4'hb});
    acc(1'b0, 8'h00, 8'h00, {7'h00, strap});
    acc(1'b0, 8'h01, 8'h00, 8'h01);
    acc(1'b0, 8'h02, 8'h00, 8'h03);
  endtask : t_reset
  task automatic t_unmapped;
    acc(1'b1, 8'h07, 8'hff, 8'h00);
    acc(1'b0, 8'h07, 8'h00, 8'h00);
    cmp(outs(), 8'h0b);
  endtask : t_unmapped
  task automatic t_int;
    acc(1'b1, 8'h01, 8'hfe, 8'h00);
    cmp(outs(), 8'h07);
    acc(1'b0, 8'h01, 8'h00, 8'h02);
    acc(1'b1, 8'h01, 8'h01, 8'h00);
  endtask : t_int
  task automatic t_switch;
    acc(1'b1, 8'h00, 8'h03, 8'h00);
    // the pulse is two cycles long, the length set at the instance
    cmp({7'h00, tile_reset}, 8'h01);
    @(negedge clock);
    cmp({7'h00, tile_reset}, 8'h01);
    @(negedge clock);
    cmp({7'h00, tile_reset}, 8'h00);
    acc(1'b0, 8'h00, 8'h00, 8'h03);
    acc(1'b1, 8'h02, 8'hfc, 8'h00);
    cmp(outs(), 8'h18);
    acc(1'b0, 8'h02, 8'h00, 8'h00);
    acc(1'b1, 8'h02, 8'h03, 8'h00);
    acc(1'b1, 8'h00, 8'h00, 8'h00);
    cmp({7'h00, tile_reset}, 8'h00);
    cmp(outs(), 8'h0b);
    acc(1'b1, 8'h00, 8'h02, 8'h00);
    cmp({7'h00, tile_reset}, 8'h00);
  endtask : t_switch
  initial begin
    t_reset(1'b1);
    t_reset(1'b0);
    t_unmapped();
    t_int();
    t_switch();
    complete_run();
  end
endmodule : tb_top
bind osc_select_ctrl osc_select_ctrl_checker #(.TILE_RESET_LEN(TILE_RESET_LEN)) chk (
  .clock            (clock),
  .rstn             (rstn),
  .reg_sel          (reg_sel),
  .reg_wr           (reg_wr),
  .reg_ack          (reg_ack),
  .source_sel       (source_sel),
  .int_osc_enable   (int_osc_enable),
  .int_osc_slow     (int_osc_slow),
  .xtal_enable      (xtal_enable),
  .xtal_bias_enable (xtal_bias_enable),
  .tile_reset       (tile_reset),
  .reg_addr         (reg_addr),
  .reg_wdata        (reg_wdata),
  .reg_rdata        (reg_rdata)
);
